/* File: pkg/ezr_pkg.sv */
/*
 * Constants, register map and bus carrier for the zero-run and
 * national-bit-seven change registers of one receive framer channel.
 * Assumes one 200 MHz clock and a synchronous microprocessor port whose
 * strobes already sit in that clock's domain.
 */
// How it works
// - state is declared when at least 2 of the last 3 bit-seven samples are 0
// - status bit 5 shows the live bit-seven zero state; writes ignored
// - status bit 1 latches on every rise and fall of that state
// - change flags hold until status is read; the read clears them
// - status bit 0 latches when zero-run detection starts and when it ends
// - enable bit 1 gates the bit-seven change interrupt; resets to 0
// - enable bit 0 gates the zero-run change interrupt; resets to 0
`default_nettype none
package ezr_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam logic [14:0] STATUS_ADDR = 15'h0B0E;
	localparam logic [14:0] ENABLE_ADDR = 15'h0B0F;
	localparam int ZR_FLAG_BIT = 0;
	localparam int S7_FLAG_BIT = 1;
	localparam int S7_STATE_BIT = 5;
	localparam int ZR_EN_BIT = 0;
	localparam int S7_EN_BIT = 1;
	localparam int OBS_DEPTH = 3;
	localparam int ZERO_QUORUM = 2;
	localparam logic [2:0] OBS_RESET = 3'h7;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam logic [1:0] ENABLE_RESET = 2'h0;

	typedef struct packed {
		logic rd;
		logic wr;
		logic [14:0] addr;
		logic [7:0] wdata;
	} ezr_bus_req_s;
endpackage : ezr_pkg
`default_nettype wire

/* File: rtl/ezr_regs.sv */
/*
 * Status and interrupt enable registers for the bit-seven zero state and
 * the zero-run condition, with read-to-clear change flags.
 * Assumes bus strobes, bit-seven sample strobe and zero-run level are all
 * produced by logic on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
module ezr_regs (
	input wire logic sys_clk,
	input wire logic nrst,
	input wire ezr_pkg::ezr_bus_req_s bus_req,
	input wire logic national_bit_seven,
	input wire logic national_bit_seven_vld,
	input wire logic zero_run_det,
	output logic [7:0] rd_data_r,
	output logic irq_r
);
	logic [2:0] obs_r;
	logic sa7_zero_state_r;
	logic sa7_zero_state_nxt;
	logic zero_run_det_d_r;
	logic sa7_zero_change_flag_r;
	logic zero_run_change_flag_r;
	logic sa7_zero_change_irq_en_r;
	logic zero_run_change_irq_en_r;
	logic [2:0] obs_nxt;
	logic [1:0] zero_cnt;
	logic status_rd;
	logic enable_rd;
	logic enable_wr;
	logic s7_evt;
	logic zr_evt;
	logic [7:0] status_val;
	logic [7:0] enable_val;

	assign status_rd = bus_req.rd && bus_req.addr == ezr_pkg::STATUS_ADDR;
	assign enable_rd = bus_req.rd && bus_req.addr == ezr_pkg::ENABLE_ADDR;
	assign enable_wr = bus_req.wr && bus_req.addr == ezr_pkg::ENABLE_ADDR;

	// newest sample enters bit 0; window of the last three samples
	assign obs_nxt = {obs_r[1:0], national_bit_seven};
	always_comb begin
		zero_cnt = 2'h0;
		for (int i = 0; i < ezr_pkg::OBS_DEPTH; i++) begin
			zero_cnt = zero_cnt + {1'b0, ~obs_nxt[i]};
		end
		sa7_zero_state_nxt = zero_cnt >= 2'(ezr_pkg::ZERO_QUORUM);
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			obs_r <= ezr_pkg::OBS_RESET;
			sa7_zero_state_r <= 1'b0;
		end else if (national_bit_seven_vld) begin
			obs_r <= obs_nxt;
			sa7_zero_state_r <= sa7_zero_state_nxt;
		end
	end

	assign s7_evt = national_bit_seven_vld &&
		(sa7_zero_state_nxt != sa7_zero_state_r);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			zero_run_det_d_r <= 1'b0;
		end else begin
			zero_run_det_d_r <= zero_run_det;
		end
	end

	assign zr_evt = zero_run_det != zero_run_det_d_r;

	// a new event in the cycle of the read survives the clear
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			sa7_zero_change_flag_r <= 1'b0;
			zero_run_change_flag_r <= 1'b0;
		end else begin
			if (s7_evt) begin
				sa7_zero_change_flag_r <= 1'b1;
			end else if (status_rd) begin
				sa7_zero_change_flag_r <= 1'b0;
			end
			if (zr_evt) begin
				zero_run_change_flag_r <= 1'b1;
			end else if (status_rd) begin
				zero_run_change_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			{sa7_zero_change_irq_en_r, zero_run_change_irq_en_r} <=
				ezr_pkg::ENABLE_RESET;
		end else if (enable_wr) begin
			sa7_zero_change_irq_en_r <=
				bus_req.wdata[ezr_pkg::S7_EN_BIT];
			zero_run_change_irq_en_r <=
				bus_req.wdata[ezr_pkg::ZR_EN_BIT];
		end
	end

	always_comb begin
		status_val = ezr_pkg::DATA_RESET;
		status_val[ezr_pkg::S7_STATE_BIT] = sa7_zero_state_r;
		status_val[ezr_pkg::S7_FLAG_BIT] = sa7_zero_change_flag_r;
		status_val[ezr_pkg::ZR_FLAG_BIT] = zero_run_change_flag_r;
		enable_val = ezr_pkg::DATA_RESET;
		enable_val[ezr_pkg::S7_EN_BIT] = sa7_zero_change_irq_en_r;
		enable_val[ezr_pkg::ZR_EN_BIT] = zero_run_change_irq_en_r;
	end

	// read data is captured on the read strobe and holds until the next read
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			rd_data_r <= ezr_pkg::DATA_RESET;
		end else if (bus_req.rd) begin
			rd_data_r <= status_rd ? status_val :
				enable_rd ? enable_val : ezr_pkg::DATA_RESET;
		end
	end

	// follows the flags one cycle later
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= (sa7_zero_change_flag_r && sa7_zero_change_irq_en_r) ||
				(zero_run_change_flag_r && zero_run_change_irq_en_r);
		end
	end

	property p_zr_flag_holds;
		@(posedge sys_clk) disable iff (!nrst)
		zero_run_change_flag_r && !status_rd |=> zero_run_change_flag_r;
	endproperty
	a_zr_flag_holds: assert property (p_zr_flag_holds)
		else $error("zero-run change flag dropped without a read");

	property p_state_two_of_three;
		@(posedge sys_clk) disable iff (!nrst)
		national_bit_seven_vld && (obs_nxt == 3'h0 || obs_nxt == 3'h1 ||
			obs_nxt == 3'h2 || obs_nxt == 3'h4) |=> sa7_zero_state_r;
	endproperty
	a_state_two_of_three: assert property (p_state_two_of_three)
		else $error("zero state not declared on two zero samples");

	property p_state_clear;
		@(posedge sys_clk) disable iff (!nrst)
		national_bit_seven_vld && (obs_nxt == 3'h7 || obs_nxt == 3'h6 ||
			obs_nxt == 3'h5 || obs_nxt == 3'h3) |=> !sa7_zero_state_r;
	endproperty
	a_state_clear: assert property (p_state_clear)
		else $error("zero state declared with fewer than two zeros");

	property p_live_bit;
		@(posedge sys_clk) disable iff (!nrst)
		status_rd |=> rd_data_r[5] == $past(sa7_zero_state_r) &&
			rd_data_r[4:2] == 3'h0;
	endproperty
	a_live_bit: assert property (p_live_bit)
		else $error("status bit 5 does not show live zero state");

	property p_s7_flag_set;
		@(posedge sys_clk) disable iff (!nrst)
		$changed(sa7_zero_state_r) |-> sa7_zero_change_flag_r;
	endproperty
	a_s7_flag_set: assert property (p_s7_flag_set)
		else $error("bit-seven change flag missed a state change");

	property p_read_clears;
		@(posedge sys_clk) disable iff (!nrst)
		status_rd && !s7_evt && !zr_evt |=>
			!sa7_zero_change_flag_r && !zero_run_change_flag_r;
	endproperty
	a_read_clears: assert property (p_read_clears)
		else $error("status read did not clear change flags");

	property p_flag_holds;
		@(posedge sys_clk) disable iff (!nrst)
		sa7_zero_change_flag_r && !status_rd |=> sa7_zero_change_flag_r;
	endproperty
	a_flag_holds: assert property (p_flag_holds)
		else $error("change flag dropped without a read");

	property p_zr_flag_set;
		@(posedge sys_clk) disable iff (!nrst)
		$rose(zero_run_det) or $fell(zero_run_det) |=>
			zero_run_change_flag_r;
	endproperty
	a_zr_flag_set: assert property (p_zr_flag_set)
		else $error("zero-run change flag missed an edge");

	property p_en_s7;
		@(posedge sys_clk) disable iff (!nrst)
		enable_wr |=> sa7_zero_change_irq_en_r == $past(bus_req.wdata[1]);
	endproperty
	a_en_s7: assert property (p_en_s7)
		else $error("bit-seven enable not written");

	property p_en_zr;
		@(posedge sys_clk) disable iff (!nrst)
		enable_wr |=> zero_run_change_irq_en_r == $past(bus_req.wdata[0]);
	endproperty
	a_en_zr: assert property (p_en_zr)
		else $error("zero-run enable not written");

	property p_irq;
		@(posedge sys_clk) disable iff (!nrst)
		##1 irq_r == $past((sa7_zero_change_flag_r &&
			sa7_zero_change_irq_en_r) || (zero_run_change_flag_r &&
			zero_run_change_irq_en_r));
	endproperty
	a_irq: assert property (p_irq)
		else $error("interrupt request does not match enabled flags");

	property p_irq_drops;
		@(posedge sys_clk) disable iff (!nrst)
		status_rd && !s7_evt && !zr_evt |-> ##2 !irq_r;
	endproperty
	a_irq_drops: assert property (p_irq_drops)
		else $error("interrupt request stayed up after flags cleared");
endmodule : ezr_regs
`default_nettype wire

/* File: test/ezr_host.sv */
/* host model driving the register bus of ezr_regs.
 * assumes requests are issued just after a rising edge of sys_clk. */
`timescale 1ns/1ps
`default_nettype none
module ezr_host (
	input wire logic sys_clk,
	output var ezr_pkg::ezr_bus_req_s bus_req
);
	initial bus_req = '0;
	// one strobe cycle, then address and data lines go to the inverse
	task automatic xfer(input logic w, input logic [14:0] a,
		input logic [7:0] d);
		@(posedge sys_clk) #1;
		bus_req = '{rd: !w, wr: w, addr: a, wdata: d};
		@(posedge sys_clk) #1;
		bus_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
	endtask : xfer
endmodule : ezr_host
`default_nettype wire

/* File: test/ezr_regs_tb_top.sv */
/* self-checking bench for ezr_regs.
 * assumes ezr_host drives the bus; assertions live in the design. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin failures++; \
	$display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module ezr_regs_tb_top;
	logic sys_clk = 1'b0;
	logic nrst = 1'b0;
	logic bit7 = 1'b1;
	logic bit7_vld = 1'b0;
	logic zr_det = 1'b0;
	logic [7:0] rd_data;
	logic irq;
	ezr_pkg::ezr_bus_req_s bus_req;
	int failures = 0;
	int checks_done = 0;
	logic [3:0] rows [7] = '{4'b0001, 4'b0011, 4'b0110, 4'b1110,
		4'b0101, 4'b1001, 4'b1100};
	always #2.5 sys_clk = ~sys_clk;
	ezr_host host_u (.sys_clk(sys_clk), .bus_req(bus_req));
	ezr_regs dut_u (.sys_clk(sys_clk), .nrst(nrst), .bus_req(bus_req),
		.national_bit_seven(bit7), .national_bit_seven_vld(bit7_vld),
		.zero_run_det(zr_det), .rd_data_r(rd_data), .irq_r(irq));
	task automatic rd_chk(input logic [14:0] a, input logic [7:0] e);
		host_u.xfer(1'b0, a, 8'h00);
		`CHK(rd_data, e)
	endtask : rd_chk
	task automatic sample(input logic b);
		@(posedge sys_clk) #1;
		bit7 = b;
		bit7_vld = 1'b1;
		@(posedge sys_clk) #1;
		bit7_vld = 1'b0;
		bit7 = ~b;
	endtask : sample
	task automatic irq_chk(input logic e);
		repeat (3) @(posedge sys_clk);
		#1;
		`CHK(irq, e)
	endtask : irq_chk
	task automatic finish_test;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test
	initial begin
		#20000;
		failures++;
		finish_test();
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h00);
		rd_chk(ezr_pkg::ENABLE_ADDR, 8'h00);
		for (int i = 0; i < 7; i++) begin
			for (int k = 3; k > 0; k--) sample(rows[i][k]);
			host_u.xfer(1'b0, ezr_pkg::STATUS_ADDR, 8'h00);
			`CHK(rd_data & 8'h20, {2'b00, rows[i][0], 5'h00})
		end
		host_u.xfer(1'b1, ezr_pkg::ENABLE_ADDR, 8'hFF);
		rd_chk(ezr_pkg::ENABLE_ADDR, 8'h03);
		host_u.xfer(1'b1, ezr_pkg::STATUS_ADDR, 8'hFF);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h00);
		zr_det = 1'b1;
		irq_chk(1'b1);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h01);
		irq_chk(1'b0);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h00);
		zr_det = 1'b0;
		irq_chk(1'b1);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h01);
		sample(1'b0);
		sample(1'b0);
		irq_chk(1'b1);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h22);
		sample(1'b1);
		sample(1'b1);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h02);
		host_u.xfer(1'b1, ezr_pkg::ENABLE_ADDR, 8'h00);
		zr_det = 1'b1;
		irq_chk(1'b0);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h01);
		rd_chk(15'h0B10, 8'h00);
		// state change lands in the very cycle of a status read
		sample(1'b0);
		fork
			host_u.xfer(1'b0, ezr_pkg::STATUS_ADDR, 8'h00);
			sample(1'b0);
		join
		`CHK(rd_data, 8'h00)
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h22);
		// reset in mid-run with a pending interrupt
		host_u.xfer(1'b1, ezr_pkg::ENABLE_ADDR, 8'h03);
		zr_det = 1'b0;
		irq_chk(1'b1);
		@(posedge sys_clk) #1;
		nrst = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		nrst = 1'b1;
		`CHK(irq, 1'b0)
		rd_chk(ezr_pkg::ENABLE_ADDR, 8'h00);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h00);
		sample(1'b0);
		sample(1'b0);
		irq_chk(1'b0);
		rd_chk(ezr_pkg::STATUS_ADDR, 8'h22);
		finish_test();
	end
endmodule : ezr_regs_tb_top
`default_nettype wire
